// ==== include/gpd_defines.vh ====
`ifndef GPD_DEFINES_VH
`define GPD_DEFINES_VH

// ------------------------------------------------------------
// register byte addresses
// ------------------------------------------------------------
`define GPD_ADDR_PIN_INPUT_LEVELS   8'h00
`define GPD_ADDR_OUTPUT_LATCH       8'h04
`define GPD_ADDR_DIRECTION_CONTROL  8'h08
`define GPD_ADDR_ANALOG_SELECT      8'h0c
`define GPD_ADDR_CONFIG_WORD_THREE_HIGH           8'h10
`define GPD_ADDR_PERIPH_ENABLE      8'h14

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define GPD_RST_OUTPUT_LATCH        8'h00
`define GPD_RST_DIRECTION_CONTROL   8'hff
`define GPD_RST_ANALOG_SELECT       8'hff
`define GPD_RST_CONFIG_WORD_THREE_HIGH            8'hbf
`define GPD_RST_PERIPH_ENABLE       8'h00

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define GPD_CFG_PWM_B_ALT_BIT       5
`define GPD_CFG_MASK                8'hbf
`define GPD_PEN_SPI_BIT             0
`define GPD_PEN_I2C_BIT             1
`define GPD_PEN_CAPTURE_COMPARE_FOUR_BIT            2
`define GPD_PEN_PWM2B_BIT           3
`define GPD_PEN_PWM2C_BIT           4
`define GPD_PEN_PWM2D_BIT           5
`define GPD_PEN_PWM1B_BIT           6
`define GPD_PEN_MASK                8'h7f

// ------------------------------------------------------------
// axi responses
// ------------------------------------------------------------
`define GPD_RESP_OKAY               2'b00
`define GPD_RESP_SLVERR             2'b10

`endif

// ==== src/gpd_pin_mux.v ====
`timescale 1ns/10ps
`include "gpd_defines.vh"

// ------------------------------------------------------------
// per-pin output select, combinational
// ------------------------------------------------------------
module gpd_pin_mux (
	input  wire [7:0] output_latch,
	input  wire [7:0] direction_control,
	input  wire [7:0] periph_enable,
	input  wire       pwm_b_pin_alternate,
	input  wire       spi_clock_two_out,
	input  wire       i2c_clock_two_out,
	input  wire       i2c_data_two_out,
	input  wire       capture_compare_four_out,
	input  wire       pwm_unit2_out_b,
	input  wire       pwm_unit2_out_c,
	input  wire       pwm_unit2_out_d,
	input  wire       spi_data_out_two,
	input  wire       pwm_unit1_out_b,
	output reg  [7:0] pin_value,
	output reg  [7:0] pin_oe_n
);
	wire en_spi;
	wire en_i2c;
	wire en_ccp;
	wire en_p2b;
	wire en_p2c;
	wire en_p2d;
	wire en_p1b;

	assign en_spi = periph_enable[`GPD_PEN_SPI_BIT];
	assign en_i2c = periph_enable[`GPD_PEN_I2C_BIT];
	assign en_ccp = periph_enable[`GPD_PEN_CAPTURE_COMPARE_FOUR_BIT];
	// alternate pin 2 only when the select bit is clear
	assign en_p2b = periph_enable[`GPD_PEN_PWM2B_BIT]
		& ~pwm_b_pin_alternate;
	assign en_p2c = periph_enable[`GPD_PEN_PWM2C_BIT];
	assign en_p2d = periph_enable[`GPD_PEN_PWM2D_BIT];
	assign en_p1b = periph_enable[`GPD_PEN_PWM1B_BIT];

	always @* begin
		// latch is the fallback; pins 6 and 7 have no peripheral here
		pin_value = output_latch;
		// driver off when direction bit is one
		pin_oe_n = direction_control;
		// pin 0: spi clock over i2c clock
		if (en_spi) begin
			pin_value[0] = spi_clock_two_out;
		end else if (en_i2c) begin
			pin_value[0] = i2c_clock_two_out;
		end
		// pin 1: compare output over i2c data
		if (en_ccp) begin
			pin_value[1] = capture_compare_four_out;
		end else if (en_i2c) begin
			pin_value[1] = i2c_data_two_out;
		end
		if (en_p2b) begin
			pin_value[2] = pwm_unit2_out_b;
		end
		if (en_p2c) begin
			pin_value[3] = pwm_unit2_out_c;
		end
		// pin 4: pwm over spi data out
		if (en_p2d) begin
			pin_value[4] = pwm_unit2_out_d;
		end else if (en_spi) begin
			pin_value[4] = spi_data_out_two;
		end
		if (en_p1b) begin
			pin_value[5] = pwm_unit1_out_b;
		end
	end
endmodule

// ==== src/gpd_port.v ====
// Design decisions made here: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/10ps
`include "gpd_defines.vh"

// Operation
// - eight pins, each input or output, direction chosen per pin.
// - direction bit one turns the pin driver off, pin is input.
// - direction bit zero drives the output latch value on the pin.
// - output latch is its own register; reads return latch, not pins.
// - after reset every pin is an analog input.
// - several enabled outputs on a pin: highest priority wins.
// - analog functions connect only while analog select is set.
// - digital outputs still drive a pin in analog mode.
// - analog mode disables digital input; latch output unaffected.
// - pin 0: spi clock, i2c clock, analog channel 20.
// - pin 1: compare/capture 4, spi data in, i2c data, analog 21.
// - pin 2: pwm unit 2 output b, analog channel 22.
// - pin 3: pwm unit 2 output c, spi client select input.
// - pin 4: pwm unit 2 output d or spi data out, analog 24.
// - pin 5: pwm unit 1 output b, analog channel 25.
// - pwm 2 output b on pin 2 only when select bit is clear.
module gpd_port (
	input  wire        clk,
	input  wire        nrst,
	input  wire [7:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output reg         s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output reg         s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [7:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output reg         s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	input  wire [7:0]  pin_in,
	output reg  [7:0]  pin_out,
	output reg  [7:0]  pin_oe_n,
	output reg  [7:0]  analog_connect,
	input  wire        spi_clock_two_out,
	input  wire        i2c_clock_two_out,
	input  wire        i2c_data_two_out,
	input  wire        capture_compare_four_out,
	input  wire        pwm_unit2_out_b,
	input  wire        pwm_unit2_out_c,
	input  wire        pwm_unit2_out_d,
	input  wire        spi_data_out_two,
	input  wire        pwm_unit1_out_b,
	output reg         spi_clock_two_in,
	output reg         i2c_clock_two_in,
	output reg         capture_compare_four_in,
	output reg         spi_data_in_two,
	output reg         i2c_data_two_in,
	output reg         spi_client_select_two
);
	reg  [7:0]  output_latch_q;
	reg  [7:0]  direction_control_q;
	reg  [7:0]  analog_select_q;
	reg  [7:0]  config_word_three_high_q;
	reg  [7:0]  periph_enable_q;
	reg  [7:0]  pin_input_levels_q;
	reg  [7:0]  aw_addr_q;
	reg         aw_full_q;
	reg  [31:0] w_data_q;
	reg  [3:0]  w_strb_q;
	reg         w_full_q;
	wire [7:0]  mux_value;
	wire [7:0]  mux_oe_n;
	wire [7:0]  digital_in;
	wire        do_write;
	wire        do_read;
	wire        aw_take;
	wire        w_take;
	wire        b_done;
	wire        r_done;
	wire        aw_hit;
	wire        ar_hit;
	wire        wr_latch;
	wire        wr_dir;
	wire        wr_ana;
	wire        wr_cfg;
	wire        wr_pen;
	wire        wr_lane;
	wire        select_heard;
	reg  [7:0]  output_latch_d;
	reg  [7:0]  direction_control_d;
	reg  [7:0]  analog_select_d;
	reg  [7:0]  config_word_three_high_d;
	reg  [7:0]  periph_enable_d;

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function [7:0] merge_byte;
		input [7:0] old_val;
		input [7:0] new_val;
		input       strobe;
		begin
			merge_byte = strobe ? new_val : old_val;
		end
	endfunction

	function addr_known;
		input [7:0] addr;
		begin
			case (addr)
			`GPD_ADDR_PIN_INPUT_LEVELS,
			`GPD_ADDR_OUTPUT_LATCH,
			`GPD_ADDR_DIRECTION_CONTROL,
			`GPD_ADDR_ANALOG_SELECT,
			`GPD_ADDR_CONFIG_WORD_THREE_HIGH,
			`GPD_ADDR_PERIPH_ENABLE: addr_known = 1'b1;
			default: addr_known = 1'b0;
			endcase
		end
	endfunction

	// ------------------------------------------------------------
	// output multiplexer
	// ------------------------------------------------------------
	gpd_pin_mux u_mux (
		.output_latch             (output_latch_q),
		.direction_control        (direction_control_q),
		.periph_enable            (periph_enable_q),
		.pwm_b_pin_alternate      (config_word_three_high_q[
			`GPD_CFG_PWM_B_ALT_BIT]),
		.spi_clock_two_out        (spi_clock_two_out),
		.i2c_clock_two_out        (i2c_clock_two_out),
		.i2c_data_two_out         (i2c_data_two_out),
		.capture_compare_four_out (capture_compare_four_out),
		.pwm_unit2_out_b          (pwm_unit2_out_b),
		.pwm_unit2_out_c          (pwm_unit2_out_c),
		.pwm_unit2_out_d          (pwm_unit2_out_d),
		.spi_data_out_two         (spi_data_out_two),
		.pwm_unit1_out_b          (pwm_unit1_out_b),
		.pin_value                (mux_value),
		.pin_oe_n                 (mux_oe_n)
	);

	// analog select has no say in the output path
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			pin_out <= 8'h00;
			pin_oe_n <= 8'hff;
			analog_connect <= 8'hff;
		end else begin
			pin_out <= mux_value;
			pin_oe_n <= mux_oe_n;
			analog_connect <= analog_select_q;
		end
	end

	// ------------------------------------------------------------
	// digital input path
	// ------------------------------------------------------------
	// analog pins read as zero
	assign digital_in = pin_in & ~analog_select_q;
	// select only heard while pin 3 is a digital input
	assign select_heard = direction_control_q[3] & ~analog_select_q[3];

	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			pin_input_levels_q <= 8'h00;
			spi_clock_two_in <= 1'b0;
			i2c_clock_two_in <= 1'b0;
			capture_compare_four_in <= 1'b0;
			spi_data_in_two <= 1'b0;
			i2c_data_two_in <= 1'b0;
			spi_client_select_two <= 1'b1;
		end else begin
			pin_input_levels_q <= digital_in;
			spi_clock_two_in <= digital_in[0];
			i2c_clock_two_in <= digital_in[0];
			capture_compare_four_in <= digital_in[1];
			spi_data_in_two <= digital_in[1];
			i2c_data_two_in <= digital_in[1];
			spi_client_select_two <= select_heard ?
				digital_in[3] : 1'b1;
		end
	end

	// ------------------------------------------------------------
	// axi4-lite write channel
	// ------------------------------------------------------------
	// response waits until address and data are both held
	assign do_write = aw_full_q & w_full_q & ~s_axi_bvalid;
	assign aw_take = s_axi_awvalid & s_axi_awready;
	assign w_take = s_axi_wvalid & s_axi_wready;
	assign b_done = s_axi_bvalid & s_axi_bready;
	assign aw_hit = addr_known(aw_addr_q);

	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			aw_full_q <= 1'b0;
			aw_addr_q <= 8'h00;
			w_full_q <= 1'b0;
			w_data_q <= 32'h0000_0000;
			w_strb_q <= 4'h0;
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `GPD_RESP_OKAY;
		end else begin
			if (aw_take) begin
				aw_full_q <= 1'b1;
				aw_addr_q <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (w_take) begin
				w_full_q <= 1'b1;
				w_data_q <= s_axi_wdata;
				w_strb_q <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (do_write) begin
				aw_full_q <= 1'b0;
				w_full_q <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= aw_hit ? `GPD_RESP_OKAY : `GPD_RESP_SLVERR;
			end
			if (b_done) begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	// ------------------------------------------------------------
	// register file
	// ------------------------------------------------------------
	// writes to the input level register land in the latch
	assign wr_latch = do_write
		&& (aw_addr_q == `GPD_ADDR_OUTPUT_LATCH
		|| aw_addr_q == `GPD_ADDR_PIN_INPUT_LEVELS);
	assign wr_dir = do_write
		&& aw_addr_q == `GPD_ADDR_DIRECTION_CONTROL;
	assign wr_ana = do_write
		&& aw_addr_q == `GPD_ADDR_ANALOG_SELECT;
	assign wr_cfg = do_write
		&& aw_addr_q == `GPD_ADDR_CONFIG_WORD_THREE_HIGH;
	assign wr_pen = do_write
		&& aw_addr_q == `GPD_ADDR_PERIPH_ENABLE;
	// each register lives in byte lane 0
	assign wr_lane = w_strb_q[0];

	always @* begin
		output_latch_d = output_latch_q;
		direction_control_d = direction_control_q;
		analog_select_d = analog_select_q;
		config_word_three_high_d = config_word_three_high_q;
		periph_enable_d = periph_enable_q;
		if (wr_latch) begin
			output_latch_d = merge_byte(output_latch_q,
				w_data_q[7:0], wr_lane);
		end
		if (wr_dir) begin
			direction_control_d = merge_byte(direction_control_q,
				w_data_q[7:0], wr_lane);
		end
		if (wr_ana) begin
			analog_select_d = merge_byte(analog_select_q,
				w_data_q[7:0], wr_lane);
		end
		if (wr_cfg) begin
			config_word_three_high_d = merge_byte(
				config_word_three_high_q,
				w_data_q[7:0] & `GPD_CFG_MASK, wr_lane);
		end
		if (wr_pen) begin
			periph_enable_d = merge_byte(periph_enable_q,
				w_data_q[7:0] & `GPD_PEN_MASK, wr_lane);
		end
	end

	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			output_latch_q <= `GPD_RST_OUTPUT_LATCH;
			direction_control_q <= `GPD_RST_DIRECTION_CONTROL;
			analog_select_q <= `GPD_RST_ANALOG_SELECT;
			config_word_three_high_q <= `GPD_RST_CONFIG_WORD_THREE_HIGH;
			periph_enable_q <= `GPD_RST_PERIPH_ENABLE;
		end else begin
			output_latch_q <= output_latch_d;
			direction_control_q <= direction_control_d;
			analog_select_q <= analog_select_d;
			config_word_three_high_q <= config_word_three_high_d;
			periph_enable_q <= periph_enable_d;
		end
	end

	// ------------------------------------------------------------
	// axi4-lite read channel
	// ------------------------------------------------------------
	assign do_read = s_axi_arvalid & s_axi_arready;
	assign r_done = s_axi_rvalid & s_axi_rready;
	// unmapped reads answer with an error and zero data
	assign ar_hit = addr_known(s_axi_araddr);

	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= `GPD_RESP_OKAY;
		end else begin
			if (do_read) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= ar_hit ? `GPD_RESP_OKAY : `GPD_RESP_SLVERR;
				case (s_axi_araddr)
				`GPD_ADDR_PIN_INPUT_LEVELS:
					s_axi_rdata <= {24'h000000, pin_input_levels_q};
				`GPD_ADDR_OUTPUT_LATCH:
					s_axi_rdata <= {24'h000000,
						output_latch_q};
				`GPD_ADDR_DIRECTION_CONTROL:
					s_axi_rdata <= {24'h000000, direction_control_q};
				`GPD_ADDR_ANALOG_SELECT:
					s_axi_rdata <= {24'h000000, analog_select_q};
				`GPD_ADDR_CONFIG_WORD_THREE_HIGH:
					s_axi_rdata <= {24'h000000,
						config_word_three_high_q};
				`GPD_ADDR_PERIPH_ENABLE:
					s_axi_rdata <= {24'h000000, periph_enable_q};
				default: begin
					s_axi_rdata <= 32'h0000_0000;
				end
				endcase
			end
			if (r_done) begin
				s_axi_rvalid <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end
endmodule

// ==== testbench/gpd_board.sv ====
`timescale 1ns/10ps
// ------------------------------------------------------------
// board level on the port pins
// ------------------------------------------------------------
module gpd_board (
	input  wire [7:0] pin_out,
	input  wire [7:0] pin_oe_n,
	input  wire [7:0] ext_level,
	output wire [7:0] pin_level
);
	// port wins where its driver is on, else the board level
	assign pin_level = (pin_oe_n & ext_level) | (~pin_oe_n & pin_out);
endmodule

// ==== testbench/gpd_port_chk.sv ====
`timescale 1ns/10ps
// ------------------------------------------------------------
// port checks
// ------------------------------------------------------------
module gpd_port_chk (
	input wire        clk,
	input wire        nrst,
	input wire        s_axi_awvalid,
	input wire        s_axi_awready,
	input wire        s_axi_wvalid,
	input wire        s_axi_wready,
	input wire [1:0]  s_axi_bresp,
	input wire        s_axi_bvalid,
	input wire        s_axi_bready,
	input wire        s_axi_arvalid,
	input wire        s_axi_arready,
	input wire [31:0] s_axi_rdata,
	input wire [1:0]  s_axi_rresp,
	input wire        s_axi_rvalid,
	input wire        s_axi_rready,
	input wire [7:0]  pin_oe_n,
	input wire [7:0]  analog_connect,
	input wire        spi_clock_two_in,
	input wire        i2c_clock_two_in,
	input wire        capture_compare_four_in,
	input wire        spi_data_in_two,
	input wire        i2c_data_two_in,
	input wire        spi_client_select_two
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);
	property p_wr_answer;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|-> ##[1:3] s_axi_bvalid;
	endproperty
	a_wr_answer: assert property (p_wr_answer)
		else $error("write response missing");
	property p_rd_answer;
		s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid;
	endproperty
	a_rd_answer: assert property (p_rd_answer)
		else $error("read response missing");
	property p_b_hold;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	a_b_hold: assert property (p_b_hold)
		else $error("write response dropped");
	property p_r_hold;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	a_r_hold: assert property (p_r_hold)
		else $error("read data dropped");
	property p_busy;
		(s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		and (s_axi_rvalid |-> !s_axi_arready && s_axi_rdata[31:8] == 24'h0);
	endproperty
	a_busy: assert property (p_busy)
		else $error("channel ready while answer pending");
	property p_dir_by_write;
		!$stable(pin_oe_n) |-> $past(s_axi_bvalid) || $past(s_axi_bvalid, 2);
	endproperty
	a_dir_by_write: assert property (p_dir_by_write)
		else $error("driver enable moved without a write");
	property p_ana_by_write;
		!$stable(analog_connect) |-> $past(s_axi_bvalid) || $past(s_axi_bvalid, 2);
	endproperty
	a_ana_by_write: assert property (p_ana_by_write)
		else $error("analog connect moved without a write");
	property p_ana_mask;
		analog_connect[1:0] == 2'h3 && $past(analog_connect[1:0]) == 2'h3
		|-> !spi_clock_two_in && !i2c_clock_two_in && !capture_compare_four_in
		&& !spi_data_in_two && !i2c_data_two_in;
	endproperty
	a_ana_mask: assert property (p_ana_mask)
		else $error("digital input seen in analog mode");
	property p_ss_idle;
		(analog_connect[3] || !pin_oe_n[3])
		&& $past(analog_connect[3] || !pin_oe_n[3]) |-> spi_client_select_two;
	endproperty
	a_ss_idle: assert property (p_ss_idle)
		else $error("client select active while not a digital input");
	c_wr: cover property (s_axi_bvalid && s_axi_bready);
	c_rd: cover property (s_axi_rvalid && s_axi_rready);
	c_err: cover property (s_axi_rvalid && s_axi_rresp == 2'b10);
	c_ss: cover property (!spi_client_select_two);
endmodule

// ==== testbench/gpd_port_tb.sv ====
`timescale 1ns/10ps
`include "gpd_defines.vh"
// ------------------------------------------------------------
// bench
// ------------------------------------------------------------
module gpd_port_tb;
	logic        clk = 0, nrst = 0;
	logic [7:0]  awaddr = 0, araddr = 0, ext = 0;
	logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic [31:0] wdata = 0, rd;
	logic [8:0]  po = 0;
	logic [1:0]  rs;
	logic [7:0]  lat, pen, cfg, dir, ans, lvl;
	wire         awready, wready, bvalid, arready, rvalid;
	wire         sck_i, scl_i, ccp_i, sdi_i, sda_i, ss_i;
	wire  [1:0]  bresp, rresp;
	wire  [31:0] rdata;
	wire  [7:0]  pin_in, pin_out, pin_oe_n, ana;
	int          fail_count = 0, compares = 0, cyc = 0, seed;
	logic [7:0]  rst_tab [7] = '{8'h00, 8'h00, 8'hff, 8'hff, 8'hbf, 8'h00, 8'h00};

	always #10 clk = ~clk;

	gpd_port u_gpd_port (.clk(clk), .nrst(nrst), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .pin_in(pin_in), .pin_out(pin_out),
		.pin_oe_n(pin_oe_n), .analog_connect(ana), .spi_clock_two_out(po[0]),
		.i2c_clock_two_out(po[1]), .i2c_data_two_out(po[2]),
		.capture_compare_four_out(po[3]), .pwm_unit2_out_b(po[4]),
		.pwm_unit2_out_c(po[5]), .pwm_unit2_out_d(po[6]),
		.spi_data_out_two(po[7]), .pwm_unit1_out_b(po[8]),
		.spi_clock_two_in(sck_i), .i2c_clock_two_in(scl_i),
		.capture_compare_four_in(ccp_i), .spi_data_in_two(sdi_i),
		.i2c_data_two_in(sda_i), .spi_client_select_two(ss_i));
	gpd_board u_gpd_board (.pin_out(pin_out), .pin_oe_n(pin_oe_n),
		.ext_level(ext), .pin_level(pin_in));

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			fail_count++;
			$display("FAIL %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic finish_test;
		if (fail_count == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		awaddr <= a;
		wdata <= {24'h0, d};
		awvalid <= 1;
		wvalid <= 1;
		repeat (20) begin
			@(posedge clk);
			if (awready) awvalid <= 0;
			if (wready) wvalid <= 0;
			if (bvalid && bready) break;
			// answer is left waiting a cycle before it is taken
			if (bvalid) bready <= 1;
		end
		rs = bresp;
		bready <= 0;
		check(bvalid, 1);
	endtask

	task automatic rd_reg(input logic [7:0] a);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1;
		repeat (20) begin
			@(posedge clk);
			if (arready) arvalid <= 0;
			if (rvalid && rready) break;
			if (rvalid) rready <= 1;
		end
		rd = rdata;
		rs = rresp;
		rready <= 0;
		check(rvalid, 1);
	endtask

	// expected pin value from latch, enables and peripheral outputs
	function automatic logic [7:0] exp_pins(input logic [7:0] l, e,
		input logic c5, input logic [8:0] p);
		exp_pins = l;
		if (e[0]) exp_pins[0] = p[0]; else if (e[1]) exp_pins[0] = p[1];
		if (e[2]) exp_pins[1] = p[3]; else if (e[1]) exp_pins[1] = p[2];
		if (e[3] && !c5) exp_pins[2] = p[4];
		if (e[4]) exp_pins[3] = p[5];
		if (e[5]) exp_pins[4] = p[6]; else if (e[0]) exp_pins[4] = p[7];
		if (e[6]) exp_pins[5] = p[8];
	endfunction

	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			fail_count++;
			finish_test();
		end
	end

	initial begin
		seed = $urandom(32'hfc36);
		repeat (10) @(posedge clk);
		nrst <= 1;
		@(posedge clk);
		check(pin_oe_n, 8'hff);
		check(ana, 8'hff);
		check(ss_i, 1);
		for (int i = 0; i < 7; i++) begin
			rd_reg(8'(i * 4));
			check(rd, {24'h0, rst_tab[i]});
			check(rs, i == 6 ? `GPD_RESP_SLVERR : `GPD_RESP_OKAY);
		end
		wr(8'h18, 8'h55);
		check(rs, `GPD_RESP_SLVERR);
		wr(8'h10, 8'hff);
		rd_reg(8'h10);
		check(rd, 32'hbf);
		for (int i = 0; i < 40; i++) begin
			{lat, pen, cfg, dir, ans} = 40'({$urandom, $urandom});
			if (i == 0) {pen, cfg, dir, ans} = {8'h7f, 8'h00, 8'h00, 8'hff};
			if (i == 1) {pen, cfg, dir} = {8'h03, 8'hff, 8'h00};
			if (i == 2) {dir, ans} = {8'hff, 8'h00};
			po <= 9'($urandom);
			ext <= 8'($urandom);
			wr(i[0] ? 8'h00 : 8'h04, lat);
			wr(8'h08, dir);
			wr(8'h0c, ans);
			wr(8'h10, cfg);
			wr(8'h14, pen);
			repeat (3) @(posedge clk);
			check(pin_out, exp_pins(lat, pen, cfg[5], po));
			check(pin_oe_n, dir);
			check(ana, ans);
			rd_reg(8'h04);
			check(rd, {24'h0, lat});
			lvl = (dir & ext) | (~dir & exp_pins(lat, pen, cfg[5], po));
			rd_reg(8'h00);
			check(rd, {24'h0, lvl & ~ans});
			check({sck_i, scl_i}, {2{lvl[0] & ~ans[0]}});
			check({ccp_i, sdi_i, sda_i}, {3{lvl[1] & ~ans[1]}});
			check(ss_i, (dir[3] && !ans[3]) ? lvl[3] : 1'b1);
		end
		finish_test();
	end
endmodule

bind gpd_port gpd_port_chk u_gpd_port_chk (.clk(clk), .nrst(nrst),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
	.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
	.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready), .pin_oe_n(pin_oe_n),
	.analog_connect(analog_connect), .spi_clock_two_in(spi_clock_two_in),
	.i2c_clock_two_in(i2c_clock_two_in),
	.capture_compare_four_in(capture_compare_four_in),
	.spi_data_in_two(spi_data_in_two), .i2c_data_two_in(i2c_data_two_in),
	.spi_client_select_two(spi_client_select_two));
